// ### do_assign_top.v
// Purpose: five digital output assign paths with an avalon register slave
// Assumes: sources and release key are synchronous to clk
// Notes:   outputs 0..1 are control outputs, 2..4 event outputs
//          map per output n: config word at 0x00+8n, assign word at
//          0x04+8n; release command at 0x40, status at 0x44
//          config: op 2:0, input polarity 7:4, final polarity 8,
//          latch 13:12; assign: four 6-bit selects, A lowest
//          final polarity and latch writes are dropped unless the
//          output is fitted and the new op is a bit function, so one
//          word can open the function and set both at once
//          every request costs two cycles; no pipelining is offered
//          since settings change rarely and area is scarce
`timescale 1ns/1ps
`include "do_assign_map.vh"

module do_assign_top
#(
   parameter NSRC = 48,
   parameter NOUT = 5
)
(
   // clock and reset
   clk,
   rst,
   // avalon-mm slave
   address,
   read,
   write,
   byteenable,
   writedata,
   readdata,
   waitrequest,
   // hardware fit and type: relay or pulse type, or event output fitted
   outFitted,
   // front key release-all pulse
   releaseKey,
   // internal event and contact sources
   srcVec,
   // digital outputs to drivers
   doOut,
   doHeld
);

   input  wire             clk;
   input  wire             rst;
   input  wire [7:0]       address;
   input  wire             read;
   input  wire             write;
   input  wire [3:0]       byteenable;
   input  wire [31:0]      writedata;
   output reg  [31:0]      readdata;
   output wire             waitrequest;
   input  wire [NOUT-1:0]  outFitted;
   input  wire             releaseKey;
   input  wire [NSRC-1:0]  srcVec;
   output wire [NOUT-1:0]  doOut;
   output wire [NOUT-1:0]  doHeld;

   reg  [`CFG_WIDTH-1:0] cfg_q [0:NOUT-1];
   reg  [`ASG_WIDTH-1:0] asg_q [0:NOUT-1];
   reg                   ack_q;
   reg                   rel_q;
   wire [31:0]           beMask;
   wire                  take;
   wire                  relCmd;

   // one wait state: the answer comes one edge after the request
   assign take        = (read | write) & ~ack_q;
   assign waitrequest = (read | write) & ~ack_q;
   assign beMask      = {{8{byteenable[3]}}, {8{byteenable[2]}},
                         {8{byteenable[1]}}, {8{byteenable[0]}}};

   // release-all command word decoded from the bus
   assign relCmd = take & write &
                   (address == `GLOBAL_CTRL_ADDR) & byteenable[0] &
                   writedata[`CTRL_RELEASE_BIT];

   // handshake state and release pulse from bus or keys
   always @(posedge clk)
   begin
      if (rst)
      begin
         ack_q <= 1'b0;
         rel_q <= 1'b0;
      end
      else
      begin
         ack_q <= take;
         rel_q <= releaseKey | relCmd;                 // see [R05]
      end
   end

   genvar g;
   generate
      for (g = 0; g < NOUT; g = g + 1)
      begin : outPath
         wire [7:0]            cfgAddr;
         wire [7:0]            asgAddr;
         wire [31:0]           cfgOld;
         wire [31:0]           cfgNew;
         wire [31:0]           asgOld;
         wire [31:0]           asgNew;
         wire [2:0]            newOp;
         wire                  canSet;
         wire [31:0]           gIdx;
         wire                  cfgHit;
         wire                  asgHit;

         // index held in a plain vector so it can be cut to 8 bits
         assign gIdx    = g;
         assign cfgAddr = `OUT_CFG_BASE + gIdx[7:0] * `OUT_STRIDE;
         assign asgAddr = `OUT_ASG_BASE + gIdx[7:0] * `OUT_STRIDE;
         // word decode for this output
         assign cfgHit  = (address == cfgAddr);
         assign asgHit  = (address == asgAddr);
         assign cfgOld  = {{(32-`CFG_WIDTH){1'b0}}, cfg_q[g]};
         assign cfgNew  = (cfgOld & ~beMask) | (writedata & beMask);
         assign asgOld  = {{(32-`ASG_WIDTH){1'b0}}, asg_q[g]};
         assign asgNew  = (asgOld & ~beMask) | (writedata & beMask);
         assign newOp   = cfgNew[`CFG_OP_MSB:`CFG_OP_LSB];
         // final polarity and latch open only to fitted outputs
         assign canSet  = outFitted[g] &&
                          newOp >= `OP_FUNC1 &&
                          newOp <= `OP_FUNC4;          // see [R07] [R08]

         // per-output setting registers
         always @(posedge clk)
         begin
            if (rst)
            begin
               cfg_q[g] <= `CFG_RESET;                 // see [R01] [R02]
               asg_q[g] <= `ASG_RESET;
            end
            else if (take & write)
            begin
               if (cfgHit)
               begin
                  cfg_q[g][`CFG_OP_MSB:`CFG_OP_LSB] <= newOp;
                  cfg_q[g][`CFG_INPOL_MSB:`CFG_INPOL_LSB] <=
                     cfgNew[`CFG_INPOL_MSB:`CFG_INPOL_LSB];
                  if (canSet)
                  begin
                     cfg_q[g][`CFG_FPOL_BIT] <=
                        cfgNew[`CFG_FPOL_BIT];         // see [R07] [R08]
                     cfg_q[g][`CFG_LATCH_MSB:`CFG_LATCH_LSB] <=
                        cfgNew[`CFG_LATCH_MSB:`CFG_LATCH_LSB];
                  end
               end
               if (asgHit)
                  asg_q[g] <= asgNew[`ASG_WIDTH-1:0];
            end
         end

         // one channel per output; the release pulse is shared so every latch
         // without a latch event in that cycle drops in the same cycle
         do_assign_channel
         #(
            .NSRC (NSRC)
         )
         chan
         (
            .clk        (clk),
            .rst        (rst),
            .srcVec     (srcVec),
            .selWord    (asg_q[g]),
            .opType     (cfg_q[g][`CFG_OP_MSB:`CFG_OP_LSB]),
            .inPol      (cfg_q[g][`CFG_INPOL_MSB:`CFG_INPOL_LSB]),
            .finalPol   (cfg_q[g][`CFG_FPOL_BIT]),
            .latchMode  (cfg_q[g][`CFG_LATCH_MSB:`CFG_LATCH_LSB]),
            .releaseAll (rel_q),
            .outQ       (doOut[g]),
            .heldQ      (doHeld[g])
         );
      end
   endgenerate

   // read mux, registered; unmapped words read zero
   // the release word reads zero: it is a command, not a state
   // status shows live outputs and held flags side by side
   integer k;
   always @(posedge clk)
   begin
      if (rst)
         readdata <= 32'h00000000;
      else if (take & read)
      begin
         readdata <= 32'h00000000;
         for (k = 0; k < NOUT; k = k + 1)
         begin
            if (address == `OUT_CFG_BASE + k[7:0] * `OUT_STRIDE)
               readdata <= {{(32-`CFG_WIDTH){1'b0}}, cfg_q[k]};
            if (address == `OUT_ASG_BASE + k[7:0] * `OUT_STRIDE)
               readdata <= {{(32-`ASG_WIDTH){1'b0}}, asg_q[k]};
         end
         if (address == `GLOBAL_STAT_ADDR)
         begin
            readdata[NOUT-1:0] <= doOut;
            readdata[`STAT_HELD_LSB +: NOUT] <= doHeld;
         end
      end
   end

endmodule // do_assign_top

// ### do_assign_map.vh
// Purpose: constants for the digital output assign logic
// Assumes: 32-bit avalon slave, byte addresses, one word per register
// Notes:   per-output registers sit at a stride of 8 bytes
// How it works
// [R01] final polarity: 0 passes, 1 inverts
// [R02] latch: 0 none, 1 hold ON, 2 hold OFF
// [R03] power-up OFF never counts as latch event
// [R04] reset clears every held latch state
// [R05] release-all command clears all held latches; a latch event in the release cycle keeps its latch held
// [R06] writing latch setting zero releases output
// [R07] control output settings need relay type, function 1-4
// [R08] event output settings need fitted hardware, function 1-4
// [R09] normally-closed source feeds constant asserted term
// [R10] function 1 is (A and B) or (C and D)
// [R11] per-input polarity bits, bit0 A to bit3 D
// [R12] order: input polarity, function, final polarity, latch
`ifndef DO_ASSIGN_MAP_VH
`define DO_ASSIGN_MAP_VH

// register offsets (bytes)
`define OUT_CFG_BASE     8'h00
`define OUT_ASG_BASE     8'h04
`define OUT_STRIDE       8'h08
`define GLOBAL_CTRL_ADDR 8'h40
`define GLOBAL_STAT_ADDR 8'h44

// configuration word fields
`define CFG_OP_LSB       0
`define CFG_OP_MSB       2
`define CFG_INPOL_LSB    4
`define CFG_INPOL_MSB    7
`define CFG_FPOL_BIT     8
`define CFG_LATCH_LSB    12
`define CFG_LATCH_MSB    13
`define CFG_WIDTH        14
`define CFG_RESET        14'h0000

// assign word: four 6-bit source selects, A lowest
`define SEL_WIDTH        6
`define ASG_WIDTH        24
`define ASG_RESET        24'h000000

// control and status fields
`define CTRL_RELEASE_BIT 0
`define STAT_HELD_LSB    8

// operation types (none, then bit functions 1-4)
`define OP_NONE          3'h0
`define OP_FUNC1         3'h1
`define OP_FUNC2         3'h2
`define OP_FUNC3         3'h3
`define OP_FUNC4         3'h4

// latch settings
`define LATCH_NONE       2'h0
`define LATCH_ON         2'h1
`define LATCH_OFF        2'h2

// source selects
`define SEL_OPEN         6'h00
`define SEL_CLOSED       6'h01
`define SEL_FIRST_SRC    6'h02

`endif

// ### do_assign_channel.v
// Purpose: one output path: input polarity, bit function, polarity, latch
// Assumes: settings come from registers on the same clock
// Notes:   output and held flag are registered
`timescale 1ns/1ps
`include "do_assign_map.vh"

module do_assign_channel
#(
   parameter NSRC = 48
)
(
   // clock and reset
   input  wire                   clk,
   input  wire                   rst,
   // sources and settings
   input  wire [NSRC-1:0]        srcVec,
   input  wire [`ASG_WIDTH-1:0]  selWord,
   input  wire [2:0]             opType,
   input  wire [3:0]             inPol,
   input  wire                   finalPol,
   input  wire [1:0]             latchMode,
   input  wire                   releaseAll,
   // result
   output reg                    outQ,
   output reg                    heldQ
);

   reg  [3:0] term;
   reg  [3:0] pol;
   reg        func;
   reg        res;
   reg        prevQ;
   reg  [1:0] modeQ;
   integer    i;
   reg  [`SEL_WIDTH-1:0] sel;

   // pick the four assign terms and apply per-input polarity
   always @*
   begin
      term = 4'h0;
      sel  = `SEL_OPEN;
      for (i = 0; i < 4; i = i + 1)
      begin
         sel = selWord[i*`SEL_WIDTH +: `SEL_WIDTH];
         if (sel == `SEL_CLOSED)
            term[i] = 1'b1;                       // see [R09]
         else if (sel >= `SEL_FIRST_SRC &&
                  sel < `SEL_FIRST_SRC + NSRC)
            term[i] = srcVec[sel - `SEL_FIRST_SRC];
         else
            term[i] = 1'b0;
      end
      pol = term ^ inPol;                         // see [R11] [R12]
   end

   // bit function then final polarity
   always @*
   begin
      case (opType)
         `OP_FUNC1: func = (pol[0] & pol[1]) | (pol[2] & pol[3]); // see [R10]
         `OP_FUNC2: func = (pol[0] | pol[1]) & (pol[2] | pol[3]);
         `OP_FUNC3: func = |pol;
         `OP_FUNC4: func = &pol;
         default:   func = 1'b0;
      endcase
      res = func ^ finalPol;                      // see [R01] [R12]
   end

   // latch stage; prevQ starts low so the power-up OFF never latches
   always @(posedge clk)
   begin
      if (rst)
      begin
         heldQ <= 1'b0;                           // see [R04]
         prevQ <= 1'b0;                           // see [R03]
         modeQ <= `LATCH_NONE;
         outQ  <= 1'b0;
      end
      else
      begin
         prevQ <= res;
         modeQ <= latchMode;
         // a latch event in the release cycle still wins
         if (latchMode == `LATCH_ON && res)
            heldQ <= 1'b1;                        // see [R02]
         else if (latchMode == `LATCH_OFF && prevQ && !res)
            heldQ <= 1'b1;                        // see [R02] [R03]
         else if (releaseAll)
            heldQ <= 1'b0;                        // see [R05]
         else if (latchMode != modeQ)
            heldQ <= 1'b0;                        // see [R06]
         if (latchMode == `LATCH_NONE)
            outQ <= res;                          // see [R06]
         else if (heldQ && latchMode == modeQ)
            outQ <= (latchMode == `LATCH_ON);     // see [R12]
         else
            outQ <= res;
      end
   end

endmodule // do_assign_channel

// ### do_assign_chk.sv
// Purpose: checker on the ports of the output assign block
// Assumes: one clock, synchronous active high reset
// Notes:   held outputs judged by cause windows of a few cycles
`timescale 1ns/1ps
module do_assign_chk
#(
   parameter NSRC = 48,
   parameter NOUT = 5
)
(
   // clock and reset
   input wire logic            clk,
   input wire logic            rst,
   // register bus
   input wire logic [7:0]      address,
   input wire logic            read,
   input wire logic            write,
   input wire logic [3:0]      byteenable,
   input wire logic [31:0]     writedata,
   input wire logic [31:0]     readdata,
   input wire logic            waitrequest,
   // sources and outputs
   input wire logic [NOUT-1:0] outFitted,
   input wire logic            releaseKey,
   input wire logic [NSRC-1:0] srcVec,
   input wire logic [NOUT-1:0] doOut,
   input wire logic [NOUT-1:0] doHeld
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // reset itself is the cause, so no disable here
   a_rst_clear: assert property (disable iff (1'h0) rst |=>
      doOut == 0 && doHeld == 0) else $error("outputs not cleared");
   a_wait_first: assert property ($rose(read || write) |-> waitrequest)
      else $error("request answered in first cycle");
   a_wait_ans: assert property ((read || write) && waitrequest |=>
      !waitrequest) else $error("answer late");
   a_unmap_zero: assert property (read && !waitrequest &&
      address == 8'h80 |-> readdata == 0) else $error("unmapped read");
   a_ctrl_zero: assert property (read && !waitrequest &&
      address == 8'h40 |-> readdata == 0) else $error("ctrl read");
   // a held output may not move while it stays held
   a_held_steady: assert property (
      ((doHeld & $past(doHeld) & (doOut ^ $past(doOut))) == 0))
      else $error("held output moved");
   a_held_drop: assert property (|($past(doHeld) & ~doHeld) |->
      $past(releaseKey) || $past(releaseKey, 2) || $past(write) ||
      $past(write, 2) || $past(rst)) else $error("held dropped");
   a_out_cause: assert property (doOut != $past(doOut) |->
      $past(srcVec) != $past(srcVec, 2) || $past(write) ||
      $past(write, 2) || $past(write, 3) || $past(releaseKey) ||
      $past(releaseKey, 2) || $past(releaseKey, 3) || $past(rst))
      else $error("output moved without cause");
endmodule // do_assign_chk

bind do_assign_top do_assign_chk #(.NSRC(NSRC), .NOUT(NOUT)) u_chk (
   .clk, .rst, .address, .read, .write, .byteenable, .writedata,
   .readdata, .waitrequest, .outFitted, .releaseKey, .srcVec, .doOut,
   .doHeld);

// ### do_driver_model.sv
// Purpose: output driver model, contact picks up one cycle late
// Assumes: doOut is a level per output
// Notes:   coil lag delays every change but the reset drop by one cycle; one-cycle glitches still reach the load
`timescale 1ns/1ps
module do_driver_model
(
   // clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // drive from the block
   input wire logic [4:0] doOut,
   // contact state seen by the load
   output logic [4:0]     contactOn
);
   // contacts drop at once on reset
   always @(posedge clk)
      contactOn <= rst ? 5'h00 : doOut;
endmodule // do_driver_model

// ### do_assign_tb_top.sv
// Purpose: self-checking bench for the output assign block
// Assumes: 10 MHz clock, reset held two cycles
// Notes:   event output 3 left unfitted to see setting gating
`timescale 1ns/1ps
module do_assign_tb_top;
   logic        clk, rst, read, write, releaseKey, waitrequest;
   logic [7:0]  address;
   logic [3:0]  byteenable;
   logic [31:0] writedata, readdata, rdq;
   logic [4:0]  outFitted, doOut, doHeld, contactOn;
   logic [47:0] srcVec;
   int          mismatches = 0, totalChecks = 0, cyc = 0;

   do_assign_top u_dut (.clk, .rst, .address, .read, .write, .byteenable,
      .writedata, .readdata, .waitrequest, .outFitted, .releaseKey,
      .srcVec, .doOut, .doHeld);
   do_driver_model u_drv (.clk, .rst, .doOut, .contactOn);

   initial
   begin
      clk = 0;
      forever #50 clk = ~clk;
   end

   task chk(input string n, input logic [31:0] e, g);
      totalChecks++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task step(input int n);
      repeat (n) @(posedge clk);
   endtask
   // request held until waitrequest low at an edge
   // waitrequest is read once settled, mid-cycle, and counts at the
   // rising edge that follows it
   task bus(input logic rw, input logic [7:0] a, input logic [31:0] d);
      logic w;
      address <= a;
      writedata <= d;
      read <= !rw;
      write <= rw;
      w = 1'b1;
      while (w)
      begin
         @(negedge clk);
         w = waitrequest;
         @(posedge clk);
      end
      rdq = readdata;
      read <= 1'h0;
      write <= 1'h0;
      @(posedge clk);
   endtask
   function logic [31:0] cw(input [2:0] op, input [3:0] ip, input fp,
                            input [1:0] lm);
      return {18'h0, lm, 3'h0, fp, ip, 1'h0, op};
   endfunction
   task endOfTest;
      $display("checks %0d mismatches %0d", totalChecks, mismatches);
      if (mismatches == 0 && totalChecks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // hang guard, run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         mismatches++;
         endOfTest();
      end
   end

   task tReset;
      bus(0, 8'h00, 0);
      chk("cfg0", 0, rdq);
      bus(0, 8'h44, 0);
      chk("stat", 0, rdq);
      bus(0, 8'h80, 0);
      chk("unmapped", 0, rdq);
      bus(0, 8'h40, 0);
      chk("ctrl", 0, rdq);
   endtask
   // out2: A src0, C src1, B and D closed; plain, A inverted, final inverted
   task tFunc;
      logic a, e;
      bus(1, 8'h14, {8'h0, 6'h01, 6'h03, 6'h01, 6'h02});
      for (int m = 0; m < 3; m++)
      begin
         bus(1, 8'h10, cw(3'h1, {3'h0, m == 1}, m == 2, 2'h0));
         for (int k = 0; k < 4; k++)
         begin
            a = k[0] ^ (m == 1);
            e = (a | k[1]) ^ (m == 2);
            srcVec[1:0] <= k[1:0];
            step(3);
            chk("func", e, doOut[2]);
         end
      end
   endtask
   // out0 latch ON, released by key, by command, by setting zero
   task tLatchOn;
      bus(1, 8'h04, {8'h0, 12'h000, 6'h01, 6'h06});
      for (int r = 0; r < 3; r++)
      begin
         bus(1, 8'h00, cw(3'h1, 4'h0, 1'h0, 2'h1));
         srcVec[4] <= 1'h1;
         step(3);
         srcVec[4] <= 1'h0;
         step(3);
         chk("held on", 3'h7, {doOut[0], doHeld[0], contactOn[0]});
         if (r == 0)
         begin
            releaseKey <= 1'h1;
            step(1);
            releaseKey <= 1'h0;
         end
         else
            bus(1, r == 1 ? 8'h40 : 8'h00,
                r == 1 ? 32'h1 : cw(3'h1, 4'h0, 1'h0, 2'h0));
         step(3);
         chk("released", 2'h0, {doOut[0], doHeld[0]});
      end
   endtask
   // out1 latch OFF on src5, then a mid-run reset
   task tLatchOff;
      bus(1, 8'h0c, {8'h0, 12'h000, 6'h01, 6'h07});
      bus(1, 8'h08, cw(3'h1, 4'h0, 1'h0, 2'h2));
      step(3);
      chk("off init", 2'h0, {doOut[1], doHeld[1]});
      for (int k = 0; k < 3; k++)
      begin
         srcVec[5] <= !k[0];
         step(3);
         chk("off", k ? 2'h1 : 2'h2, {doOut[1], doHeld[1]});
      end
      rst <= 1'h1;
      step(2);
      rst <= 1'h0;
      step(1);
      chk("rst held", 0, doHeld);
   endtask
   // settings refused when unfitted or op outside 1..4
   task tGate;
      bus(1, 8'h18, cw(3'h1, 4'h3, 1'h1, 2'h1));
      bus(0, 8'h18, 0);
      chk("unfitted", cw(3'h1, 4'h3, 1'h0, 2'h0), rdq);
      bus(1, 8'h20, cw(3'h0, 4'h0, 1'h1, 2'h2));
      bus(0, 8'h20, 0);
      chk("op none", 0, rdq);
      bus(1, 8'h00, cw(3'h5, 4'h0, 1'h1, 2'h1));
      bus(0, 8'h00, 0);
      chk("op five", cw(3'h5, 4'h0, 1'h0, 2'h0), rdq);
   endtask

   initial
   begin
      rst = 1'h1;
      read = 1'h0;
      write = 1'h0;
      releaseKey = 1'h0;
      address = 8'h00;
      byteenable = 4'hf;
      writedata = 32'h0;
      srcVec = 48'h0;
      outFitted = 5'h17;
      step(2);
      rst <= 1'h0;
      step(1);
      tReset;
      tFunc;
      tLatchOn;
      tLatchOff;
      tGate;
      endOfTest;
   end
endmodule // do_assign_tb_top
